/* hw/audio_control_register_three.sv */
// Audio control register three: codec controls, overflow flags and register port
`timescale 1ns/10ps
`default_nettype none

module audio_control_register_three (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic enable_i, // Clock enable, freezes all state when low
  // Register port
  input wire logic [6:0] reg_addr_i,
  input wire logic reg_write_i, // One-cycle write strobe
  input wire logic reg_read_i, // One-cycle read strobe
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o, // Registered read data
  output logic reg_rvalid_o, // Read data valid, one cycle
  // Overflow events from the data paths
  input wire logic record_overflow_i,
  input wire logic left_play_overflow_i,
  input wire logic right_play_overflow_i,
  // Programmed left and right DAC volumes from elsewhere
  input wire logic [6:0] left_volume_i,
  input wire logic [6:0] right_volume_i,
  // AGC input level, from the level detector; compared with the noise floor here
  input wire logic [1:0] input_level_band_i, // Quietest band the input reaches, 0..3
  input wire logic input_below_all_i, // Input below -90 dB
  // Control outputs
  output logic [6:0] left_volume_o, // Effective left DAC volume
  output logic [6:0] right_volume_o, // Effective right DAC volume
  output logic rate_44k1_o, // High selects 44.1 kHz reference
  output logic burst_mode_o, // High selects 256-s transfer
  output logic serial_master_o, // High makes the device master
  output logic [1:0] output_swing_select_o,
  output logic [1:0] gain_control_noise_floor_o,
  output logic agc_hold_o, // AGC must not chase its target
  output logic clip_step_enable_o
);

  // ----------------------------------------
  // Writable control fields
  // ----------------------------------------
  logic [1:0] volume_link_select_q, volume_link_select_d;
  logic reference_rate_select_q, reference_rate_select_d;
  logic transfer_mode_select_q, transfer_mode_select_d;
  logic serial_role_select_q, serial_role_select_d;
  logic [1:0] output_swing_select_q, output_swing_select_d;
  logic [1:0] noise_floor_q, noise_floor_d;
  logic clip_step_enable_q, clip_step_enable_d;
  logic [2:0] flags; // record, left, right
  logic hit;
  logic rd_hit;

  assign hit = (reg_addr_i == audio_ctl3_pkg::AUDIO_CONTROL_THREE_ADDR);
  assign rd_hit = hit && reg_read_i;

  // Next values of the writable fields; flag and reserved bits of the write are dropped
  always_comb begin
    volume_link_select_d = volume_link_select_q;
    reference_rate_select_d = reference_rate_select_q;
    transfer_mode_select_d = transfer_mode_select_q;
    serial_role_select_d = serial_role_select_q;
    output_swing_select_d = output_swing_select_q;
    noise_floor_d = noise_floor_q;
    clip_step_enable_d = clip_step_enable_q;
    if (hit && reg_write_i) begin
      volume_link_select_d =
        reg_wdata_i[audio_ctl3_pkg::VOL_LINK_HI:audio_ctl3_pkg::VOL_LINK_LO];
      reference_rate_select_d = reg_wdata_i[audio_ctl3_pkg::REF_RATE_BIT];
      transfer_mode_select_d = reg_wdata_i[audio_ctl3_pkg::XFER_MODE_BIT];
      serial_role_select_d = reg_wdata_i[audio_ctl3_pkg::ROLE_BIT];
      output_swing_select_d = reg_wdata_i[audio_ctl3_pkg::SWING_HI:audio_ctl3_pkg::SWING_LO];
      noise_floor_d = reg_wdata_i[audio_ctl3_pkg::NOISE_HI:audio_ctl3_pkg::NOISE_LO];
      clip_step_enable_d = reg_wdata_i[audio_ctl3_pkg::CLIP_STEP_BIT];
    end
  end

  // Field registers
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      volume_link_select_q <= audio_ctl3_pkg::CTRL_RESET[15:14];
      reference_rate_select_q <= audio_ctl3_pkg::CTRL_RESET[13];
      transfer_mode_select_q <= audio_ctl3_pkg::CTRL_RESET[12];
      serial_role_select_q <= audio_ctl3_pkg::CTRL_RESET[11];
      output_swing_select_q <= audio_ctl3_pkg::CTRL_RESET[10:9];
      noise_floor_q <= audio_ctl3_pkg::CTRL_RESET[5:4];
      clip_step_enable_q <= audio_ctl3_pkg::CTRL_RESET[3];
    end else if (enable_i) begin
      volume_link_select_q <= volume_link_select_d;
      reference_rate_select_q <= reference_rate_select_d;
      transfer_mode_select_q <= transfer_mode_select_d;
      serial_role_select_q <= serial_role_select_d;
      output_swing_select_q <= output_swing_select_d;
      noise_floor_q <= noise_floor_d;
      clip_step_enable_q <= clip_step_enable_d;
    end
  end

  // ----------------------------------------
  // Overflow flags
  // ----------------------------------------
  // A read clears; a write never does
  audio_ctl3_sticky u_sticky (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .enable_i(enable_i),
    .event_i({record_overflow_i, left_play_overflow_i, right_play_overflow_i}),
    .clear_i(rd_hit),
    .flag_o(flags)
  );

  // ----------------------------------------
  // Derived outputs
  // ----------------------------------------
  logic [6:0] left_vol_d, right_vol_d;
  logic hold_d;
  logic [15:0] rdata_d;

  // Volume linking, noise gate and read word
  always_comb begin
    left_vol_d = left_volume_i;
    right_vol_d = right_volume_i;
    if (volume_link_select_q == audio_ctl3_pkg::VOL_LINK_LEFT_FOLLOWS_RIGHT) begin
      left_vol_d = right_volume_i;
    end else if (volume_link_select_q == audio_ctl3_pkg::VOL_LINK_RIGHT_FOLLOWS_LEFT) begin
      right_vol_d = left_volume_i;
    end
    // Band index grows with depth: 0 is -60 dB, 3 is -90 dB
    hold_d = input_below_all_i || (input_level_band_i >= noise_floor_q);
    rdata_d = {volume_link_select_q, reference_rate_select_q, transfer_mode_select_q,
               serial_role_select_q, output_swing_select_q, flags, noise_floor_q,
               clip_step_enable_q, audio_ctl3_pkg::RESERVED_LOW_VALUE};
  end

  // Output registers; read data capture flags before the clear lands
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      left_volume_o <= 7'h00;
      right_volume_o <= 7'h00;
      rate_44k1_o <= 1'b0;
      burst_mode_o <= 1'b0;
      serial_master_o <= 1'b0;
      output_swing_select_o <= 2'h0;
      gain_control_noise_floor_o <= 2'h0;
      agc_hold_o <= 1'b0;
      clip_step_enable_o <= 1'b0;
      reg_rdata_o <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end else if (enable_i) begin
      left_volume_o <= left_vol_d;
      right_volume_o <= right_vol_d;
      rate_44k1_o <= reference_rate_select_q;
      burst_mode_o <= transfer_mode_select_q;
      serial_master_o <= serial_role_select_q;
      output_swing_select_o <= output_swing_select_q;
      gain_control_noise_floor_o <= noise_floor_q;
      agc_hold_o <= hold_d;
      clip_step_enable_o <= clip_step_enable_q;
      reg_rvalid_o <= rd_hit;
      reg_rdata_o <= rd_hit ? rdata_d : 16'h0000;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  flag_sticky_a: assert property (
    enable_i && record_overflow_i ##1 (enable_i && !rd_hit) [*3] |-> flags[2])
    else $error("record flag lost");
  flag_set_a: assert property (
    enable_i && left_play_overflow_i |=> flags[1])
    else $error("left flag not set");
  right_set_a: assert property (
    enable_i && right_play_overflow_i |=> flags[0])
    else $error("right flag not set");
  read_clear_a: assert property (
    enable_i && rd_hit && !record_overflow_i |=> !flags[2])
    else $error("read did not clear");
  write_keep_a: assert property (
    enable_i && hit && reg_write_i && !rd_hit && flags[2] |=> flags[2])
    else $error("write cleared flag");
  link_left_a: assert property (
    enable_i && volume_link_select_q == audio_ctl3_pkg::VOL_LINK_LEFT_FOLLOWS_RIGHT
    |=> left_volume_o == $past(right_volume_i))
    else $error("left link wrong");
  link_right_a: assert property (
    enable_i && volume_link_select_q == audio_ctl3_pkg::VOL_LINK_RIGHT_FOLLOWS_LEFT
    |=> right_volume_o == $past(left_volume_i))
    else $error("right link wrong");
  // Field outputs follow a write two edges later: field register, then output register
  rate_out_a: assert property (
    enable_i && hit && reg_write_i ##1 enable_i
    |=> rate_44k1_o == $past(reg_wdata_i[audio_ctl3_pkg::REF_RATE_BIT], 2))
    else $error("rate wrong");
  burst_out_a: assert property (
    enable_i && hit && reg_write_i ##1 enable_i
    |=> burst_mode_o == $past(reg_wdata_i[audio_ctl3_pkg::XFER_MODE_BIT], 2))
    else $error("mode wrong");
  role_out_a: assert property (
    enable_i && hit && reg_write_i ##1 enable_i
    |=> serial_master_o == $past(reg_wdata_i[audio_ctl3_pkg::ROLE_BIT], 2))
    else $error("role wrong");
  swing_out_a: assert property (
    enable_i && hit && reg_write_i ##1 enable_i
    |=> output_swing_select_o
        == $past(reg_wdata_i[audio_ctl3_pkg::SWING_HI:audio_ctl3_pkg::SWING_LO], 2))
    else $error("swing wrong");
  clip_out_a: assert property (
    enable_i && hit && reg_write_i ##1 enable_i
    |=> clip_step_enable_o == $past(reg_wdata_i[audio_ctl3_pkg::CLIP_STEP_BIT], 2))
    else $error("clip wrong");
  hold_gate_a: assert property (
    enable_i && input_below_all_i |=> agc_hold_o)
    else $error("hold missing");
  read_word_a: assert property (
    enable_i && rd_hit |=> reg_rvalid_o
    && reg_rdata_o[8] == $past(flags[2]) && reg_rdata_o[2:0] == 3'h0)
    else $error("read word wrong");
  // A low clock enable must hold flags and the read answer where they are
  freeze_keep_a: assert property (
    !enable_i |=> $stable(flags) && $stable(reg_rvalid_o) && $stable(rate_44k1_o))
    else $error("state moved while frozen");
  idle_data_a: assert property (
    !reg_rvalid_o |-> reg_rdata_o == 16'h0000)
    else $error("stray read data");

  read_cov_c: cover property (enable_i && rd_hit && flags != 3'h0);
  link_cov_c: cover property (volume_link_select_q == 2'h2);
  race_cov_c: cover property (enable_i && rd_hit && record_overflow_i);
  freeze_cov_c: cover property (!enable_i && hit && reg_write_i);

endmodule : audio_control_register_three

`default_nettype wire

/* hw/audio_ctl3_pkg.sv */
// Package: offsets, field positions, reset values and encodings of audio control register three
package audio_ctl3_pkg;

  // ----------------------------------------
  // Register location
  // ----------------------------------------
  localparam logic [6:0] AUDIO_CONTROL_THREE_ADDR = 7'h06; // Register index on the register port

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int VOL_LINK_HI = 15;
  localparam int VOL_LINK_LO = 14;
  localparam int REF_RATE_BIT = 13;
  localparam int XFER_MODE_BIT = 12;
  localparam int ROLE_BIT = 11;
  localparam int SWING_HI = 10;
  localparam int SWING_LO = 9;
  localparam int REC_OVF_BIT = 8;
  localparam int LEFT_OVF_BIT = 7;
  localparam int RIGHT_OVF_BIT = 6;
  localparam int NOISE_HI = 5;
  localparam int NOISE_LO = 4;
  localparam int CLIP_STEP_BIT = 3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] CTRL_RESET = 16'h0000; // All writable fields clear
  localparam logic [2:0] RESERVED_LOW_VALUE = 3'h0; // Arbitrary content of the low reserved field

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  localparam logic [1:0] VOL_LINK_LEFT_FOLLOWS_RIGHT = 2'h1;
  localparam logic [1:0] VOL_LINK_RIGHT_FOLLOWS_LEFT = 2'h2;

endpackage : audio_ctl3_pkg

/* hw/audio_ctl3_sticky.sv */
// Sticky overflow flags, one per channel, cleared only by a register read or by reset
`timescale 1ns/10ps
`default_nettype none

module audio_ctl3_sticky (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic [2:0] event_i, // Overflow event pulses
  input wire logic clear_i, // Register read pulse
  output logic [2:0] flag_o // Registered flags
);

  // ----------------------------------------
  // Per-flag storage
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_flag
      logic flag_d;
      logic flag_q;
      // Set wins over clear so an event in the read cycle is not lost
      always_comb begin
        flag_d = flag_q;
        if (clear_i) begin
          flag_d = 1'b0;
        end
        if (event_i[g]) begin
          flag_d = 1'b1;
        end
      end
      always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
          flag_q <= 1'b0;
        end else if (enable_i) begin
          flag_q <= flag_d;
        end
      end
      assign flag_o[g] = flag_q;
    end
  endgenerate

endmodule : audio_ctl3_sticky

`default_nettype wire

/* testbench/host_model.sv */
// Host model: drives the register port of control register three
`timescale 1ns/10ps
`default_nettype none

module host_model #(
  parameter bit FAST_REF = 1'b0 // Host runs a reference above 48 kHz
) (
  input wire logic clk_i,
  output logic [6:0] reg_addr_o,
  output logic reg_write_o,
  output logic reg_read_o,
  output logic [15:0] reg_wdata_o,
  input wire logic [15:0] reg_rdata_i,
  input wire logic reg_rvalid_i
);
  // ------------------------------
  // Idle levels at time zero
  // ------------------------------
  initial begin
    reg_addr_o = 7'h00;
    reg_write_o = 1'b0;
    reg_read_o = 1'b0;
    reg_wdata_o = 16'h0000;
  end

  // One-cycle write; released data shows the inverse, never a stale copy
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= FAST_REF ? (d & 16'hdfff) : d;
    reg_write_o <= 1'b1;
    @(posedge clk_i);
    reg_write_o <= 1'b0;
    reg_wdata_o <= ~d;
  endtask : wr

  // One-cycle read; the answer is taken one edge after the strobe
  task automatic rd(input logic [6:0] a, output logic v, output logic [15:0] q);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_read_o <= 1'b1;
    @(posedge clk_i);
    reg_read_o <= 1'b0;
    reg_addr_o <= ~a;
    #1;
    v = reg_rvalid_i;
    q = reg_rdata_i;
  endtask : rd
endmodule : host_model

`default_nettype wire

/* testbench/testbench.sv */
// Testbench: random and corner stimulus for audio control register three
`timescale 1ns/10ps
`default_nettype none

module testbench;
  // ------------------------------
  // Signals
  // ------------------------------
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic enable_i = 1'b1; // Clock enable, dropped once to test the freeze
  logic [6:0] addr;
  logic wr_s, rd_s, rvalid, r44, bm, sm, hold, clip;
  logic [15:0] wdata, rdata;
  logic rec = 1'b0, lft = 1'b0, rgt = 1'b0, below = 1'b0;
  logic [6:0] lv_i = 7'h00, rv_i = 7'h00, lv_o, rv_o;
  logic [1:0] band = 2'h0, swing, floor_o;
  logic [31:0] seed = 32'he0ec9b9f;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #2.5 clk_i = ~clk_i;

  host_model host_u (.clk_i(clk_i), .reg_addr_o(addr), .reg_write_o(wr_s),
    .reg_read_o(rd_s), .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));

  audio_control_register_three dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .enable_i(enable_i), .reg_addr_i(addr), .reg_write_i(wr_s), .reg_read_i(rd_s),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .record_overflow_i(rec), .left_play_overflow_i(lft), .right_play_overflow_i(rgt),
    .left_volume_i(lv_i), .right_volume_i(rv_i), .input_level_band_i(band),
    .input_below_all_i(below), .left_volume_o(lv_o), .right_volume_o(rv_o),
    .rate_44k1_o(r44), .burst_mode_o(bm), .serial_master_o(sm),
    .output_swing_select_o(swing), .gain_control_noise_floor_o(floor_o),
    .agc_hold_o(hold), .clip_step_enable_o(clip));

  // ------------------------------
  // Helpers
  // ------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Effective volume of one side for a link code
  function automatic logic [6:0] vol(input logic [1:0] c, input logic [6:0] l,
                                     input logic [6:0] r, input logic left);
    if (c == 2'h1) return r;
    if (c == 2'h2) return l;
    return left ? l : r;
  endfunction : vol

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic results;
    if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    logic v;
    logic [15:0] q, w;
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    host_u.rd(7'h06, v, q);
    check("reset word", q, audio_ctl3_pkg::CTRL_RESET);
    for (int i = 0; i < 24; i++) begin
      w = 16'(rnd());
      if (i < 4) w[15:14] = i[1:0]; // Every link code once
      if (i == 4) w = 16'hffff; // All ones, flags and reserved included
      @(posedge clk_i); // Inputs change on the rising edge
      lv_i <= 7'(rnd());
      rv_i <= 7'(rnd());
      band <= 2'(rnd());
      below <= 1'(rnd());
      host_u.wr(7'h06, w);
      repeat (2) @(posedge clk_i);
      #1;
      check("left vol", lv_o, vol(w[15:14], lv_i, rv_i, 1'b1));
      check("right vol", rv_o, vol(w[15:14], lv_i, rv_i, 1'b0));
      check("rate mode role", {r44, bm, sm}, w[13:11]);
      check("swing", swing, w[10:9]);
      check("floor", floor_o, w[5:4]);
      check("agc hold", hold, below | (band >= w[5:4]));
      check("clip step", clip, w[3]);
      host_u.rd(7'h06, v, q);
      check("rvalid", v, 1'b1);
      check("readback", q, w & 16'hfe38);
    end
    // Each flag alone, survives a write of ones, clears on read
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_i);
      {rec, lft, rgt} <= 3'b100 >> k;
      @(posedge clk_i);
      {rec, lft, rgt} <= 3'b000;
      host_u.wr(7'h06, 16'hffff);
      host_u.rd(7'h06, v, q);
      check("flag set", q[8:6], 3'b100 >> k);
      host_u.rd(7'h06, v, q);
      check("flag clear", q[8:6], 3'b000);
    end
    // Event in the read cycle: the word shows the old flag, set wins the clear
    fork
      host_u.rd(7'h06, v, q);
      begin
        @(posedge clk_i);
        rec <= 1'b1;
        @(posedge clk_i);
        rec <= 1'b0;
      end
    join
    check("race word", q[8:6], 3'b000);
    host_u.rd(7'h06, v, q);
    check("race kept", q[8:6], 3'b100);
    // Other addresses give no answer and change nothing
    host_u.wr(7'h05, 16'h0000);
    host_u.rd(7'h07, v, q);
    check("unmapped rvalid", v, 1'b0);
    check("unmapped rdata", q, 16'h0000);
    host_u.rd(7'h06, v, q);
    check("after unmapped", q, 16'hfe38);
    // Clock enable low: a write, a read and an event all go unseen
    @(posedge clk_i);
    enable_i <= 1'b0;
    rec <= 1'b1;
    host_u.wr(7'h06, 16'h0000);
    host_u.rd(7'h06, v, q);
    check("frozen rvalid", v, 1'b0);
    @(posedge clk_i);
    enable_i <= 1'b1;
    rec <= 1'b0;
    host_u.rd(7'h06, v, q);
    check("after freeze", q, 16'hfe38);
    // Reset in mid-run clears fields and flags; an event during it is dropped
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    rgt <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rgt <= 1'b0;
    host_u.rd(7'h06, v, q);
    check("reset again", q, audio_ctl3_pkg::CTRL_RESET);
    check("reset outs", {r44, bm, sm, swing, floor_o, clip}, 16'h0);
    results();
  end
endmodule : testbench

`default_nettype wire
